// *** logic/tso_pkg.sv ***
package tso_pkg;
  // descriptor field widths
  localparam int TYPE_W = 4;
  localparam int PAYLOAD_LEN_W = 20;
  localparam int MSS_W = 16;
  localparam int HEADER_LEN_W = 8;
  localparam int BYTE_W = 8;
  localparam int FLAGS_W = 4;
  // code of the context descriptor kind, segmentation or checksum
  localparam logic [TYPE_W-1:0] CTX_TYPE_CODE = 4'h0;
  // report flag positions
  localparam int FLAG_DONE = 0;
  localparam int FLAG_BAD_TYPE = 1;
  localparam int FLAG_SEG = 2;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 4'h0;
  // internal storage
  localparam int HDR_DEPTH = 256;
  localparam int PAY_DEPTH = 2048;
  localparam int PAY_AW = 11;
  localparam int FIFO_DEPTH = 8;
  // count reset value
  localparam logic [MSS_W-1:0] CNT_RESET = 16'h0000;
endpackage : tso_pkg

// *** logic/byte_fifo.sv ***
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage needs no reset; only written slots are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule : byte_fifo

// *** logic/tso_framer.sv ***
// Behaviour
// - payload length is total payload bytes, spread over needed frames
// - after header, fetch exactly payload length bytes as payload
// - payload length count decides the final frame; mark it final
// - with segmentation clear, ignore length, segment size, header fields
// - whole frame assembled internally before its first byte is sent; payload store holds 2048 bytes, longer segments wrap over it
// - status reported through report flags at descriptor write-back
// - each frame payload limited to max segment size; zero means no limit
// - first header-length bytes stored and prepended to every segment
// - set enable loads segmentation context, clear loads checksum context
`timescale 1ns/1ps
module tso_framer
  import tso_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // context descriptor
  input wire logic i_ctx_valid,
  output logic o_ctx_ready,
  input wire logic [TYPE_W-1:0] i_descriptor_type_field,
  input wire logic i_segmentation_enable_bit,
  input wire logic [PAYLOAD_LEN_W-1:0] i_payload_length,
  input wire logic [MSS_W-1:0] i_max_segment_size,
  input wire logic [HEADER_LEN_W-1:0] i_header_length,
  // write-back
  output logic o_wb_valid,
  input wire logic i_wb_ready,
  output logic [FLAGS_W-1:0] o_report_flags_field,
  output logic o_csum_ctx_load,
  // data bytes from data descriptors
  input wire logic i_data_valid,
  output logic o_data_ready,
  input wire logic [BYTE_W-1:0] i_data_byte,
  // frame output
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [BYTE_W-1:0] o_tx_byte,
  output logic o_tx_last,
  output logic o_tx_final
);
  typedef enum {S_IDLE, S_HDR, S_PAY, S_SEND_HDR, S_SEND_PAY, S_WB} state_t;

  // ************************************************************
  // segment length decode
  // ************************************************************
  function automatic logic [MSS_W-1:0] seg_size(
    input logic [MSS_W-1:0] max_segment_size,
    input logic [PAYLOAD_LEN_W-1:0] rem
  );
    // zero segment size would never finish a frame; take the rest instead
    if (max_segment_size == '0 || {4'h0, max_segment_size} >= rem)
      return rem[MSS_W-1:0];
    return max_segment_size;
  endfunction : seg_size

  state_t state;
  state_t next_state;
  logic [MSS_W-1:0] cnt;
  logic [MSS_W-1:0] next_cnt;
  logic [PAYLOAD_LEN_W-1:0] remaining;
  logic [PAYLOAD_LEN_W-1:0] next_remaining;
  logic [MSS_W-1:0] seg_len;
  logic [MSS_W-1:0] next_seg_len;
  logic last_frame;
  logic next_last_frame;
  logic [MSS_W-1:0] mss_q;
  logic [MSS_W-1:0] next_mss_q;
  logic [HEADER_LEN_W-1:0] hdr_len_q;
  logic [HEADER_LEN_W-1:0] next_hdr_len_q;
  logic next_tx_valid;
  logic [BYTE_W-1:0] next_tx_byte;
  logic next_tx_last;
  logic next_tx_final;
  logic [FLAGS_W-1:0] next_flags;
  logic next_csum_load;
  logic [BYTE_W-1:0] hdr_mem [HDR_DEPTH];
  logic [BYTE_W-1:0] pay_mem [PAY_DEPTH];
  logic fifo_valid;
  logic [BYTE_W-1:0] fifo_byte;
  logic pop;
  logic tx_load;
  logic ctx_take;

  // ************************************************************
  // input buffering
  // ************************************************************
  // plain byte stream
  // buffer boundaries are invisible here, so payload may start anywhere
  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_in_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(i_data_valid),
    .o_in_ready(o_data_ready),
    .i_in_data(i_data_byte),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_byte)
  );

  assign o_ctx_ready = (state == S_IDLE);
  // write-back waits until the last frame byte has left the output register
  assign o_wb_valid = (state == S_WB) && !o_tx_valid;
  assign ctx_take = i_ctx_valid && o_ctx_ready;
  assign pop = fifo_valid && (state == S_HDR || state == S_PAY);
  assign tx_load = (!o_tx_valid || i_tx_ready)
                   && (state == S_SEND_HDR || state == S_SEND_PAY);

  // ************************************************************
  // sequencing
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_remaining = remaining;
    next_seg_len = seg_len;
    next_last_frame = last_frame;
    next_mss_q = mss_q;
    next_hdr_len_q = hdr_len_q;
    next_tx_valid = o_tx_valid && !i_tx_ready;
    next_tx_byte = o_tx_byte;
    next_tx_last = o_tx_last;
    next_tx_final = o_tx_final;
    next_flags = o_report_flags_field;
    next_csum_load = 1'b0;
    case (state)
      S_IDLE:
      begin
        if (ctx_take)
        begin
          next_state = S_WB;
          next_flags = FLAGS_RESET;
          next_flags[FLAG_DONE] = 1'b1;
          next_cnt = CNT_RESET;
          if (i_descriptor_type_field != CTX_TYPE_CODE)
          begin
            next_flags[FLAG_BAD_TYPE] = 1'b1;
          end
          else if (i_segmentation_enable_bit)
          begin
            next_flags[FLAG_SEG] = 1'b1;
            next_mss_q = i_max_segment_size;
            next_hdr_len_q = i_header_length;
            next_remaining = i_payload_length;
            if (i_header_length != '0)
              next_state = S_HDR;
            else if (i_payload_length != '0)
              next_state = S_PAY;
            next_seg_len = seg_size(i_max_segment_size, i_payload_length);
            next_last_frame =
              ({4'h0, i_max_segment_size} >= i_payload_length)
              || (i_max_segment_size == '0);
          end
          else
          begin
            next_csum_load = 1'b1;
          end
        end
      end
      S_HDR:
      begin
        if (pop)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt[HEADER_LEN_W-1:0] == hdr_len_q - 1'b1)
          begin
            next_cnt = CNT_RESET;
            next_state = (remaining == '0) ? S_WB : S_PAY;
          end
        end
      end
      S_PAY:
      begin
        if (pop)
        begin
          next_cnt = cnt + 1'b1;
          if (cnt == seg_len - 1'b1)
          begin
            next_cnt = CNT_RESET;
            // only payload length bytes are fetched
            next_remaining = remaining - {4'h0, seg_len};
            // frame now fully held; only then start sending
            next_state = (hdr_len_q == '0) ? S_SEND_PAY : S_SEND_HDR;
          end
        end
      end
      S_SEND_HDR:
      begin
        if (tx_load)
        begin
          next_tx_valid = 1'b1;
          next_tx_byte = hdr_mem[cnt[HEADER_LEN_W-1:0]];
          next_tx_last = 1'b0;
          next_tx_final = 1'b0;
          next_cnt = cnt + 1'b1;
          if (cnt[HEADER_LEN_W-1:0] == hdr_len_q - 1'b1)
          begin
            next_cnt = CNT_RESET;
            next_state = S_SEND_PAY;
          end
        end
      end
      S_SEND_PAY:
      begin
        if (tx_load)
        begin
          next_tx_valid = 1'b1;
          next_tx_byte = pay_mem[cnt[PAY_AW-1:0]];
          next_tx_last = (cnt == seg_len - 1'b1);
          next_tx_final = (cnt == seg_len - 1'b1) && last_frame;
          next_cnt = cnt + 1'b1;
          if (cnt == seg_len - 1'b1)
          begin
            next_cnt = CNT_RESET;
            if (last_frame)
            begin
              next_state = S_WB;
            end
            else
            begin
              // last frame takes what is left
              next_state = S_PAY;
              next_seg_len = seg_size(mss_q, remaining);
              next_last_frame = ({4'h0, mss_q} >= remaining);
            end
          end
        end
      end
      S_WB:
      begin
        if (i_wb_ready && o_wb_valid)
          next_state = S_IDLE;
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= S_IDLE;
      cnt <= CNT_RESET;
      remaining <= '0;
      seg_len <= CNT_RESET;
      last_frame <= 1'b0;
      mss_q <= '0;
      hdr_len_q <= '0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= '0;
      o_tx_last <= 1'b0;
      o_tx_final <= 1'b0;
      o_report_flags_field <= FLAGS_RESET;
      o_csum_ctx_load <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      remaining <= next_remaining;
      seg_len <= next_seg_len;
      last_frame <= next_last_frame;
      mss_q <= next_mss_q;
      hdr_len_q <= next_hdr_len_q;
      o_tx_valid <= next_tx_valid;
      o_tx_byte <= next_tx_byte;
      o_tx_last <= next_tx_last;
      o_tx_final <= next_tx_final;
      o_report_flags_field <= next_flags;
      o_csum_ctx_load <= next_csum_load;
    end
  end

  // ************************************************************
  // header and payload storage
  // ************************************************************
  // single frame store: fetch of the next segment waits for the send
  always_ff @(posedge i_clk)
  begin
    if (pop && state == S_HDR)
      hdr_mem[cnt[HEADER_LEN_W-1:0]] <= fifo_byte;
    if (pop && state == S_PAY)
      pay_mem[cnt[PAY_AW-1:0]] <= fifo_byte;
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [PAYLOAD_LEN_W-1:0] pay_total;
  logic [PAYLOAD_LEN_W-1:0] pay_expect;
  always_ff @(posedge i_clk)
  begin
    if (i_srst || ctx_take)
      pay_total <= '0;
    else if (pop && state == S_PAY)
      pay_total <= pay_total + 1'b1;
    if (ctx_take)
      pay_expect <= i_payload_length;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_plain_ctx_skip: assert property (
    ctx_take && !i_segmentation_enable_bit |=> state == S_WB)
    else $error("plain context did not go straight to write-back");
  chk_csum_load: assert property (
    o_csum_ctx_load |-> $past(ctx_take && !i_segmentation_enable_bit
      && i_descriptor_type_field == CTX_TYPE_CODE))
    else $error("checksum context load without cause");
  chk_wb_flags: assert property (
    o_wb_valid |-> o_report_flags_field[FLAG_DONE])
    else $error("write-back without done flag");
  chk_seg_cap: assert property (
    state == S_PAY && mss_q != '0 |-> seg_len <= mss_q)
    else $error("segment exceeds max segment size");
  chk_payload_total: assert property (
    $rose(state == S_WB) && o_report_flags_field[FLAG_SEG]
    |-> pay_total == pay_expect)
    else $error("fetched payload differs from payload length");
  chk_full_frame: assert property (
    $rose(o_tx_valid) |-> $past(state == S_SEND_HDR
      || state == S_SEND_PAY))
    else $error("transmit started before frame was held");
  chk_final_frame: assert property (
    o_tx_valid && o_tx_final |-> o_tx_last && remaining == '0)
    else $error("final frame flagged with payload left");
  chk_last_size: assert property (
    state == S_PAY && last_frame |-> {4'h0, seg_len} == remaining)
    else $error("last frame size is not the remainder");
  chk_hdr_first: assert property (
    $rose(state == S_SEND_PAY) && hdr_len_q != '0
    |-> $past(state == S_SEND_HDR))
    else $error("payload sent without header");

  cov_seg_op: cover property (o_tx_valid && i_tx_ready && o_tx_final);
  cov_multi: cover property (o_tx_last && o_tx_valid && !o_tx_final);
  cov_csum: cover property (o_csum_ctx_load);
  cov_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule : tso_framer

// *** sim/data_src.sv ***
`timescale 1ns/1ps
// ********************************************
// host side byte source for the data descriptors
// ********************************************
module data_src (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [20:0] i_count,
  // byte stream
  output logic o_valid,
  input wire logic i_ready,
  output logic [7:0] o_byte
);
  logic [20:0] k;
  logic [20:0] total;
  logic [1:0] gap;
  // header then payload, one stream, no buffer edges
  always_ff @(posedge i_clk)
  begin
    gap <= (i_srst || gap == 2'h2) ? 2'h0 : gap + 2'h1;
    if (i_srst)
    begin
      k <= 21'h000000;
      total <= 21'h000000;
      o_valid <= 1'b0;
      o_byte <= 8'hFF;
    end
    else if (i_start)
    begin
      k <= 21'h000000;
      total <= i_count;
    end
    else if (o_valid && i_ready)
    begin
      // released data shows the inverse, never a stale match
      o_valid <= 1'b0;
      o_byte <= ~o_byte;
      k <= k + 21'h000001;
    end
    else if (!o_valid && k < total && (!i_slow || gap == 2'h2))
    begin
      o_valid <= 1'b1;
      o_byte <= k[7:0] ^ 8'h5A;
    end
  end
endmodule : data_src

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  import tso_pkg::*;
  logic i_clk, i_srst, i_ctx_valid, i_segmentation_enable_bit;
  logic i_wb_ready, i_tx_ready, i_data_valid;
  logic [TYPE_W-1:0] i_descriptor_type_field;
  logic [PAYLOAD_LEN_W-1:0] i_payload_length;
  logic [MSS_W-1:0] i_max_segment_size;
  logic [HEADER_LEN_W-1:0] i_header_length;
  logic [BYTE_W-1:0] i_data_byte;
  logic o_ctx_ready, o_wb_valid, o_csum_ctx_load, o_data_ready;
  logic [FLAGS_W-1:0] o_report_flags_field;
  logic o_tx_valid, o_tx_last, o_tx_final;
  logic [BYTE_W-1:0] o_tx_byte;
  logic src_start, src_slow, tx_stall, in_frame;
  logic [20:0] src_count;
  logic [3:0] cyc;
  logic [9:0] rx_q[$];
  int tk_q[$];
  int err_total, checks, csum_n, taken, refused;

  tso_framer dut (.i_clk, .i_srst, .i_ctx_valid, .o_ctx_ready,
    .i_descriptor_type_field, .i_segmentation_enable_bit,
    .i_payload_length, .i_max_segment_size, .i_header_length,
    .o_wb_valid, .i_wb_ready, .o_report_flags_field, .o_csum_ctx_load,
    .i_data_valid, .o_data_ready, .i_data_byte, .o_tx_valid,
    .i_tx_ready, .o_tx_byte, .o_tx_last, .o_tx_final);
  data_src src (.i_clk, .i_srst, .i_start(src_start), .i_slow(src_slow),
    .i_count(src_count), .o_valid(i_data_valid), .i_ready(o_data_ready),
    .o_byte(i_data_byte));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // ********************************************
  // sink and monitor
  // ********************************************
  always @(posedge i_clk)
  begin
    cyc <= cyc + 4'h1;
    // long stalls let the byte fifo fill and refuse
    i_tx_ready <= !tx_stall || cyc > 4'hB;
    if (o_csum_ctx_load === 1'b1) csum_n++;
    if (i_data_valid && o_data_ready === 1'b1) taken++;
    if (i_data_valid && o_data_ready === 1'b0) refused++;
    if (o_tx_valid === 1'b1 && i_tx_ready)
    begin
      if (!in_frame) tk_q.push_back(taken);
      in_frame = !o_tx_last;
      rx_q.push_back({o_tx_final, o_tx_last, o_tx_byte});
    end
  end

  task automatic check(input logic [31:0] got, exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // ********************************************
  // one context descriptor and its data
  // ********************************************
  task automatic run_op(input logic [3:0] typ, input logic en,
    input int pl, max_segment_size, hdr, input logic slow, stall,
    input logic [3:0] exp_flags);
    int c0, t0, n, off, seg, rem, f, i, k;
    logic [9:0] e;
    c0 = csum_n;
    t0 = taken;
    rx_q.delete();
    tk_q.delete();
    @(posedge i_clk);
    i_ctx_valid <= 1'b1;
    i_descriptor_type_field <= typ;
    i_segmentation_enable_bit <= en;
    i_payload_length <= PAYLOAD_LEN_W'(pl);
    i_max_segment_size <= MSS_W'(max_segment_size);
    i_header_length <= HEADER_LEN_W'(hdr);
    src_start <= 1'b1;
    src_count <= (typ == 4'h0 && en) ? 21'(hdr + pl) : 21'h000000;
    src_slow <= slow;
    tx_stall <= stall;
    n = 0;
    @(negedge i_clk);
    while (o_ctx_ready !== 1'b1 && n < 100)
    begin
      @(negedge i_clk);
      n++;
    end
    check(32'(o_ctx_ready), 1, "context ready");
    @(posedge i_clk);
    i_ctx_valid <= 1'b0;
    src_start <= 1'b0;
    n = 0;
    @(negedge i_clk);
    while (o_wb_valid !== 1'b1 && n < 4000)
    begin
      @(negedge i_clk);
      n++;
    end
    check(32'(o_wb_valid), 1, "write-back");
    check(o_report_flags_field, exp_flags, "report flags");
    @(posedge i_clk);
    i_wb_ready <= 1'b1;
    @(posedge i_clk);
    i_wb_ready <= 1'b0;
    tx_stall <= 1'b0;
    check(csum_n - c0, 32'(typ == 4'h0 && !en), "csum load");
    check(taken - t0, 32'(src_count), "bytes fetched");
    rem = (typ == 4'h0 && en) ? pl : 0;
    off = 0;
    i = 0;
    f = 0;
    while (rem > 0)
    begin
      seg = (max_segment_size == 0 || max_segment_size > rem) ? rem : max_segment_size;
      check(32'(tk_q[f] - t0 >= hdr + off + seg), 1, "frame early");
      for (n = 0; n < hdr + seg; n++)
      begin
        k = (n < hdr) ? n : off + n;
        e[7:0] = 8'(k) ^ 8'h5A;
        e[8] = (n == hdr + seg - 1);
        e[9] = e[8] && rem == seg;
        check(rx_q[i], e, "tx byte");
        i++;
      end
      off += seg;
      rem -= seg;
      f++;
    end
    check(rx_q.size(), i, "frame bytes");
    $display("test done type %0h seg %0b payload %0d", typ, en, pl);
  endtask : run_op

  initial
  begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    tally_and_finish;
  end

  // ********************************************
  // test sequence
  // ********************************************
  initial
  begin
    i_srst = 1'b1;
    {i_ctx_valid, i_segmentation_enable_bit, i_wb_ready} = 3'h0;
    i_tx_ready = 1'b1;
    i_descriptor_type_field = 4'h0;
    i_payload_length = '0;
    i_max_segment_size = '0;
    i_header_length = '0;
    {src_start, src_slow, tx_stall, in_frame} = 4'h0;
    src_count = '0;
    cyc = 4'h0;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    // segment size plus header kept far below the frame store
    run_op(4'h0, 1'b1, 3, 2, 2, 1'b0, 1'b0, 4'h5);
    run_op(4'h0, 1'b1, 40, 16, 14, 1'b1, 1'b1, 4'h5);
    check(32'(refused > 0), 1, "fifo refused");
    run_op(4'h0, 1'b1, 12, 4, 4, 1'b0, 1'b1, 4'h5);
    run_op(4'h0, 1'b1, 9, 0, 3, 1'b0, 1'b0, 4'h5);
    run_op(4'h0, 1'b1, 5, 2, 0, 1'b0, 1'b1, 4'h5);
    run_op(4'h0, 1'b1, 0, 4, 3, 1'b0, 1'b0, 4'h5);
    run_op(4'h0, 1'b0, 40, 3, 5, 1'b0, 1'b0, 4'h1);
    run_op(4'h1, 1'b1, 5, 2, 2, 1'b0, 1'b0, 4'h3);
    run_op(4'h8, 1'b1, 5, 2, 2, 1'b0, 1'b0, 4'h3);
    run_op(4'hF, 1'b0, 5, 2, 2, 1'b0, 1'b0, 4'h3);
    run_op(4'h0, 1'b1, 1, 8, 1, 1'b1, 1'b0, 4'h5);
    tally_and_finish;
  end
endmodule : tb
